//--- rtl/prog_host.sv
`timescale 1ns/100ps
`include "prog_defs.svh"

module prog_host
    import prog_pkg::*;
#(
    parameter int PAGE_BYTES = `PAGE_BYTES,
    parameter int QTR_CYC = `QTR_CYC,
    parameter int TWR_CYC = `TWR_CYC,
    // Device identity, value arbitrary
    parameter logic [6:0] DEV_ID = `DEV_ID_RST
) (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Command
    input wire logic cmd_valid_i,
    input wire cmd_t cmd_i,
    output logic cmd_ready_o,
    input wire logic mode_en_i,
    // Write data
    input wire logic wr_valid_i,
    input wire logic [7:0] wr_data_i,
    output logic wr_ready_o,
    // Response
    output rsp_t rsp_o,
    // Serial pins
    output logic prog_serial_clock_o,
    input wire logic prog_serial_data_i,
    output logic prog_serial_data_o,
    output logic prog_serial_data_oe_o,
    output logic serial_mode_select_n_o
);

    localparam int DW = $clog2(PAGE_BYTES + 1);
    localparam int QW = $clog2(QTR_CYC + 1);
    localparam int TW = $clog2(TWR_CYC + 1);

    state_t st_q;
    step_t step_q;
    cmd_t cmd_q;
    logic [2:0] ph_q;
    logic [3:0] bit_q;
    logic [1:0] acnt_q;
    logic [DW-1:0] dcnt_q;
    logic [7:0] sh_q;
    logic lsb_q;
    logic err_q;
    logic [QW-1:0] qcnt_q;
    logic [TW-1:0] poll_cnt_q;
    logic scl_q;
    logic sda_oe_q;
    logic sda_out_q;
    logic mode_sel_n_q;
    logic cmd_ready_q;
    logic wr_ready_q;
    rsp_t rsp_q;
    logic sda_s;
    logic tick;
    logic end_ph;
    logic tx_bit;
    logic rw_bit;
    logic ack_ok;
    logic [23:0] addr_m;

    // ----------------------------------------
    // Data line input synchroniser
    // ----------------------------------------
    pin_sync #(
        .INIT(1'b1)
    ) u_sda_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .pin_i(prog_serial_data_i),
        .level_o(sda_s)
    );

    // ----------------------------------------
    // Quarter-bit timebase
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            qcnt_q <= '0;
        end else if (ce_i) begin
            if (qcnt_q == '0) begin
                qcnt_q <= QW'(QTR_CYC - 1);
            end else begin
                qcnt_q <= qcnt_q - 1'b1;
            end
        end
    end

    assign tick = ce_i && (qcnt_q == '0);
    assign end_ph = tick && (ph_q == ((st_q == ST_STOP) ? `STOP_LAST_PH : `BIT_LAST_PH));
    assign tx_bit = lsb_q ? sh_q[0] : sh_q[7];
    assign rw_bit = (step_q == STEP_RHDR) || (cmd_q.op == OP_CUR_READ);
    assign ack_ok = !sda_s;
    assign addr_m = cmd_q.addr & `ADDR_USED_MASK;

    // ----------------------------------------
    // Program cycle wait window
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            poll_cnt_q <= '0;
        end else if (ce_i) begin
            if (end_ph && st_q == ST_STOP && cmd_q.op == OP_WRITE && !err_q) begin
                poll_cnt_q <= TW'(TWR_CYC);
            end else if (poll_cnt_q != '0) begin
                poll_cnt_q <= poll_cnt_q - 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Mode select held low while busy
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_sel_n_q <= 1'b1;
        end else if (ce_i) begin
            mode_sel_n_q <= !(mode_en_i || st_q != ST_IDLE || poll_cnt_q != '0);
        end
    end

    // ----------------------------------------
    // Serial pin drive
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_q <= 1'b1;
            sda_oe_q <= 1'b0;
            sda_out_q <= 1'b0;
        end else if (ce_i) begin
            sda_out_q <= 1'b0;
            if (tick) begin
                unique case (st_q)
                    ST_START: begin
                        if (ph_q == 3'h0) scl_q <= 1'b0;
                        if (ph_q == 3'h1) sda_oe_q <= 1'b0;
                        if (ph_q == 3'h2) scl_q <= 1'b1;
                        if (ph_q == 3'h3) sda_oe_q <= 1'b1;
                    end
                    ST_TX: begin
                        if (ph_q == 3'h0) scl_q <= 1'b0;
                        if (ph_q == 3'h1) sda_oe_q <= (bit_q < 4'h8) && !tx_bit;
                        if (ph_q == 3'h2) scl_q <= 1'b1;
                    end
                    ST_RX: begin
                        if (ph_q == 3'h0) scl_q <= 1'b0;
                        if (ph_q == 3'h1) sda_oe_q <= 1'b0;
                        if (ph_q == 3'h2) scl_q <= 1'b1;
                    end
                    ST_STOP: begin
                        if (ph_q == 3'h0) scl_q <= 1'b0;
                        if (ph_q == 3'h1) sda_oe_q <= 1'b1;
                        if (ph_q == 3'h2) scl_q <= 1'b1;
                        if (ph_q == 3'h3) sda_oe_q <= 1'b0;
                    end
                    ST_IDLE, ST_LOAD: begin
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Message sequencer
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= ST_IDLE;
            step_q <= STEP_HDR;
            cmd_q <= '0;
            ph_q <= 3'h0;
            bit_q <= 4'h0;
            acnt_q <= 2'h0;
            dcnt_q <= '0;
            sh_q <= 8'h00;
            lsb_q <= 1'b0;
            err_q <= 1'b0;
            cmd_ready_q <= 1'b1;
            wr_ready_q <= 1'b0;
            rsp_q <= '0;
        end else if (ce_i) begin
            rsp_q.done <= 1'b0;
            rsp_q.err <= 1'b0;
            rsp_q.rd_valid <= 1'b0;
            if (tick && st_q != ST_IDLE && st_q != ST_LOAD) begin
                ph_q <= end_ph ? 3'h0 : ph_q + 3'h1;
            end
            unique case (st_q)
                ST_IDLE: begin
                    if (cmd_valid_i && cmd_ready_q) begin
                        cmd_q <= cmd_i;
                        cmd_ready_q <= 1'b0;
                        step_q <= STEP_HDR;
                        err_q <= 1'b0;
                        dcnt_q <= '0;
                        ph_q <= 3'h0;
                        st_q <= ST_START;
                    end
                end
                ST_START: begin
                    if (end_ph) begin
                        sh_q <= {DEV_ID, rw_bit};
                        lsb_q <= 1'b0;
                        bit_q <= 4'h0;
                        st_q <= ST_TX;
                    end
                end
                ST_LOAD: begin
                    if (wr_valid_i && wr_ready_q) begin
                        wr_ready_q <= 1'b0;
                        sh_q <= wr_data_i;
                        lsb_q <= 1'b1;
                        bit_q <= 4'h0;
                        ph_q <= 3'h0;
                        st_q <= ST_TX;
                    end
                end
                ST_TX: begin
                    if (end_ph && bit_q < 4'h8) begin
                        sh_q <= lsb_q ? {1'b0, sh_q[7:1]} : {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                    end else if (end_ph && !ack_ok) begin
                        if ((step_q == STEP_HDR || step_q == STEP_RHDR) && poll_cnt_q != '0) begin
                            st_q <= ST_START;
                        end else begin
                            err_q <= 1'b1;
                            st_q <= ST_STOP;
                        end
                    end else if (end_ph) begin
                        bit_q <= 4'h0;
                        unique case (step_q)
                            STEP_HDR: begin
                                if (cmd_q.op == OP_CUR_READ) begin
                                    step_q <= STEP_RDATA;
                                    lsb_q <= 1'b1;
                                    st_q <= ST_RX;
                                end else begin
                                    step_q <= STEP_ADDR;
                                    acnt_q <= 2'h0;
                                    sh_q <= addr_m[23:16];
                                    lsb_q <= 1'b0;
                                end
                            end
                            STEP_ADDR: begin
                                if (acnt_q == 2'h0) begin
                                    acnt_q <= 2'h1;
                                    sh_q <= addr_m[15:8];
                                end else if (acnt_q == 2'h1) begin
                                    acnt_q <= 2'h2;
                                    sh_q <= addr_m[7:0];
                                end else if (cmd_q.op == OP_WRITE) begin
                                    step_q <= STEP_DATA;
                                    wr_ready_q <= 1'b1;
                                    st_q <= ST_LOAD;
                                end else begin
                                    step_q <= STEP_RHDR;
                                    st_q <= ST_START;
                                end
                            end
                            STEP_DATA: begin
                                dcnt_q <= dcnt_q + 1'b1;
                                if (dcnt_q == DW'(PAGE_BYTES - 1)) begin
                                    st_q <= ST_STOP;
                                end else begin
                                    wr_ready_q <= 1'b1;
                                    st_q <= ST_LOAD;
                                end
                            end
                            STEP_RHDR: begin
                                step_q <= STEP_RDATA;
                                lsb_q <= 1'b1;
                                st_q <= ST_RX;
                            end
                            default: begin
                                err_q <= 1'b1;
                                st_q <= ST_STOP;
                            end
                        endcase
                    end
                end
                ST_RX: begin
                    if (end_ph && bit_q < 4'h8) begin
                        sh_q <= {sda_s, sh_q[7:1]};
                        bit_q <= bit_q + 4'h1;
                    end else if (end_ph) begin
                        st_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (end_ph) begin
                        rsp_q.done <= 1'b1;
                        rsp_q.err <= err_q;
                        rsp_q.rd_valid <= (step_q == STEP_RDATA) && !err_q;
                        rsp_q.rd_data <= sh_q;
                        cmd_ready_q <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign prog_serial_clock_o = scl_q;
    assign prog_serial_data_o = sda_out_q;
    assign prog_serial_data_oe_o = sda_oe_q;
    assign serial_mode_select_n_o = mode_sel_n_q;
    assign cmd_ready_o = cmd_ready_q;
    assign wr_ready_o = wr_ready_q;
    assign rsp_o = rsp_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    property p_open_drain;
        sda_out_q == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data line driven high");

    property p_data_clock_low;
        (scl_q && $past(scl_q) && (sda_oe_q != $past(sda_oe_q)))
            |-> ($past(st_q) == ST_START || $past(st_q) == ST_STOP);
    endproperty
    a_data_clock_low: assert property (p_data_clock_low) else $error("data moved, clock high");

    property p_start_shape;
        (end_ph && st_q == ST_START) |=> (scl_q && sda_oe_q && st_q == ST_TX);
    endproperty
    a_start_shape: assert property (p_start_shape) else $error("bad start condition");

    property p_mode_low;
        (st_q != ST_IDLE && $past(st_q) != ST_IDLE && $past(ce_i)) |-> !mode_sel_n_q;
    endproperty
    a_mode_low: assert property (p_mode_low) else $error("mode select high while busy");

    property p_ack_release;
        (st_q == ST_TX && bit_q == 4'h8 && ph_q >= 3'h2) |-> !sda_oe_q;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("host held ack slot");

    property p_addr_unused_zero;
        (st_q == ST_TX && step_q == STEP_ADDR && acnt_q == 2'h0 && bit_q == 4'h0)
            |-> (sh_q[7:1] == 7'h00);
    endproperty
    a_addr_unused_zero: assert property (p_addr_unused_zero) else $error("unused bits set");

    property p_full_page;
        (st_q == ST_STOP && $past(st_q) == ST_TX && step_q == STEP_DATA && !err_q)
            |-> (dcnt_q == DW'(PAGE_BYTES));
    endproperty
    a_full_page: assert property (p_full_page) else $error("page length wrong");

    property p_poll_restart;
        (end_ph && st_q == ST_TX && bit_q == 4'h8 && sda_s && step_q == STEP_HDR
            && poll_cnt_q != '0) |=> (st_q == ST_START && scl_q);
    endproperty
    a_poll_restart: assert property (p_poll_restart) else $error("poll did not restart");

    property p_read_nack_stop;
        (end_ph && st_q == ST_RX && bit_q == 4'h8) |=> (st_q == ST_STOP && !sda_oe_q);
    endproperty
    a_read_nack_stop: assert property (p_read_nack_stop) else $error("read not ended by stop");

endmodule

//--- rtl/prog_defs.svh
`ifndef PROG_DEFS_SVH
`define PROG_DEFS_SVH

// ----------------------------------------
// Clock and serial timing
// ----------------------------------------
`define MCLK_KHZ 25000
`define QTR_NS 2500
`define QTR_CYC ((`QTR_NS * `MCLK_KHZ + 999999) / 1000000)
`define TWR_US 20000
`define TWR_CYC (`TWR_US * (`MCLK_KHZ / 1000))
`define STOP_LAST_PH 3'h5
`define BIT_LAST_PH 3'h3

// ----------------------------------------
// Addressing and page
// ----------------------------------------
`define PAGE_BYTES 128
`define ADDR_USED_MASK 24'h01ffff
`define DEV_ID_RST 7'h2b

`endif

//--- rtl/prog_pkg.sv
package prog_pkg;

    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_CUR_READ = 2'b01,
        OP_RAND_READ = 2'b10
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_TX = 3'b010,
        ST_RX = 3'b011,
        ST_LOAD = 3'b100,
        ST_STOP = 3'b101
    } state_t;

    typedef enum logic [2:0] {
        STEP_HDR = 3'b000,
        STEP_ADDR = 3'b001,
        STEP_DATA = 3'b010,
        STEP_RHDR = 3'b011,
        STEP_RDATA = 3'b100
    } step_t;

    typedef struct packed {
        op_t op;
        logic [23:0] addr;
    } cmd_t;

    typedef struct packed {
        logic done;
        logic err;
        logic rd_valid;
        logic [7:0] rd_data;
    } rsp_t;

endpackage

//--- rtl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
    parameter logic INIT = 1'b1
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Pin and filtered level
    input wire logic pin_i,
    output logic level_o
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;

    // ----------------------------------------
    // Three stages, change once two agree
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end else if (ce_i) begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lvl_q <= INIT;
        end else if (ce_i && (s2_q == s3_q)) begin
            lvl_q <= s3_q;
        end
    end

    assign level_o = lvl_q;

endmodule

//--- dv/cfg_mem_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Behavioural configuration memory
// ----------------------------------------
module cfg_mem_model #(
    parameter logic [6:0] DEV_ID = 7'h51,
    parameter int TWR_NS = 20000
) (
    // Serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    // Fault control
    input wire logic refuse_i,
    // Line drive and status
    output logic sda_oe_o,
    output logic busy_o
);
    typedef enum logic [2:0] {M_IDLE, M_RX, M_ACK, M_TX, M_TXACK} mstate_t;
    logic [7:0] mem [0:131071];
    mstate_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [23:0] addr;
    logic [16:0] cur;
    logic [16:0] last_wr;
    logic rw;
    logic wrote;
    logic ackd;
    int bidx;

    initial begin
        for (int i = 0; i < 131072; i++) begin
            mem[i] = 8'ha5 ^ i[7:0];
        end
        st = M_IDLE;
        sda_oe_o = 1'b0;
        busy_o = 1'b0;
        wrote = 1'b0;
        cur = '0;
        last_wr = '0;
    end

    // Start returns to header; no chip select here
    always @(negedge sda_i) begin
        if (scl_i === 1'b1 && busy_o === 1'b0) begin
            st = M_RX;
            cnt = '0;
            bidx = 0;
            sda_oe_o = 1'b0;
        end
    end

    // Stop after data launches timed cycle, lines ignored meanwhile
    always @(posedge sda_i) begin
        if (scl_i === 1'b1 && busy_o === 1'b0) begin
            st = M_IDLE;
            sda_oe_o = 1'b0;
            if (wrote) begin
                wrote = 1'b0;
                cur = last_wr + 17'h1;
                busy_o = 1'b1;
                #(TWR_NS);
                busy_o = 1'b0;
            end
        end
    end

    // Bits sampled on rising clock; data bytes LSB first
    always @(posedge scl_i) begin
        if (busy_o === 1'b0 && st == M_RX && cnt < 4'd8) begin
            if (bidx >= 4) begin
                sh = {sda_i, sh[7:1]};
            end else begin
                sh = {sh[6:0], sda_i};
            end
            cnt = cnt + 4'd1;
        end
    end

    // Line changes only after falling clock
    always @(negedge scl_i) begin
        if (busy_o === 1'b0) begin
            case (st)
                M_RX: if (cnt == 4'd8) begin
                    ackd = !refuse_i;
                    if (bidx == 0) begin
                        rw = sh[0];
                        ackd = ackd && (sh[7:1] == DEV_ID);
                    end else if (bidx < 4) begin
                        addr = {addr[15:0], sh};
                        if (bidx == 3) begin
                            ackd = ackd && (addr[23:17] == 7'h0);
                            cur = addr[16:0];
                        end
                    end else begin
                        mem[cur] = sh;
                        last_wr = cur;
                        cur = {cur[16:7], cur[6:0] + 7'h1};
                        wrote = 1'b1;
                    end
                    bidx++;
                    st = M_ACK;
                    sda_oe_o = ackd;
                end
                M_ACK: begin
                    sda_oe_o = 1'b0;
                    cnt = '0;
                    if (!ackd) begin
                        st = M_IDLE;
                    end else if (rw && bidx == 1) begin
                        st = M_TX;
                        sh = mem[cur];
                        cur = cur + 17'h1;
                        sda_oe_o = ~sh[0];
                    end else begin
                        st = M_RX;
                    end
                end
                M_TX: begin
                    cnt = cnt + 4'd1;
                    sda_oe_o = (cnt < 4'd8) ? ~sh[cnt[2:0]] : 1'b0;
                    if (cnt == 4'd8) begin
                        st = M_TXACK;
                    end
                end
                default: st = M_IDLE;
            endcase
        end
    end
endmodule

//--- dv/prog_host_tb_top.sv
`timescale 1ns/100ps
module prog_host_tb_top;
    import prog_pkg::*;
    // Device identity, value arbitrary
    localparam logic [6:0] DEV = 7'h51;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    cmd_t cmd_i = '0;
    logic mode_en_i = 1'b0;
    logic wr_valid_i = 1'b0;
    logic [7:0] wr_data_i = '0;
    logic refuse = 1'b0;
    logic cmd_ready_o, wr_ready_o, scl, sda_o, sda_oe, sel_n, dev_oe, dev_busy;
    rsp_t rsp_o;
    rsp_t r;
    wire sda_line = (sda_oe || dev_oe) ? 1'b0 : 1'b1;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    prog_host #(.QTR_CYC(4), .TWR_CYC(2000), .DEV_ID(DEV)) uut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
        .mode_en_i(mode_en_i), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
        .wr_ready_o(wr_ready_o), .rsp_o(rsp_o), .prog_serial_clock_o(scl),
        .prog_serial_data_i(sda_line), .prog_serial_data_o(sda_o),
        .prog_serial_data_oe_o(sda_oe), .serial_mode_select_n_o(sel_n));

    cfg_mem_model #(.DEV_ID(DEV), .TWR_NS(20000)) mem_dev (
        .scl_i(scl), .sda_i(sda_line), .refuse_i(refuse),
        .sda_oe_o(dev_oe), .busy_o(dev_busy));

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Line monitor and timeout
    // ----------------------------------------
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (sda_oe === 1'b1) check(sda_o === 1'b0, "data driven high");
        if (dev_busy === 1'b1) check(sel_n === 1'b0, "mode left in busy");
        if (cycles == 100000) begin
            num_errors++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Shared drivers
    // ----------------------------------------
    task automatic issue(input op_t op, input logic [23:0] a);
        int n;
        cmd_i <= '{op: op, addr: a};
        cmd_valid_i <= 1'b1;
        n = 0;
        do begin @(posedge mclk_i); n++; end while (cmd_ready_o !== 1'b1 && n < 100);
        cmd_valid_i <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (rsp_o.done !== 1'b1 && rsp_o.err !== 1'b1 && n < 40000);
        r = rsp_o;
        check(n < 40000, "no response");
    endtask

    task automatic write_page(input logic [23:0] a, input logic [7:0] base);
        int n;
        fork
            issue(OP_WRITE, a);
            for (int i = 0; i < 128; i++) begin
                wr_data_i <= base + i[7:0];
                wr_valid_i <= 1'b1;
                n = 0;
                do begin @(posedge mclk_i); n++; end while (wr_ready_o !== 1'b1 && n < 5000);
            end
        join
        wr_valid_i <= 1'b0;
        check(r.done === 1'b1 && r.err === 1'b0, "write not done");
        check(r.rd_valid === 1'b0, "write flagged read data");
    endtask

    task automatic read_chk(input op_t op, input logic [23:0] a, input logic [7:0] exp);
        issue(op, a);
        check(r.done === 1'b1 && r.rd_data === exp, "read data wrong");
        check(r.rd_valid === 1'b1 && r.err === 1'b0, "read not valid");
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_idle();
        check(scl === 1'b1 && sda_oe === 1'b0 && sel_n === 1'b1, "idle pins");
        mode_en_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        check(sel_n === 1'b0, "mode select");
        $display("test idle done");
    endtask

    task automatic t_refuse();
        refuse <= 1'b1;
        issue(OP_CUR_READ, 24'h0);
        check(r.err === 1'b1, "refusal not reported");
        check(r.rd_valid === 1'b0, "refused read flagged valid");
        refuse <= 1'b0;
        $display("test refuse done");
    endtask

    task automatic t_writes();
        write_page(24'h000105, 8'h10);
        check(dev_busy === 1'b1, "device not busy");
        write_page(24'h000280, 8'hc0);
        $display("test writes done");
    endtask

    task automatic t_reads();
        read_chk(OP_CUR_READ, 24'h0, 8'ha5);
        read_chk(OP_RAND_READ, 24'h000105, 8'h10);
        read_chk(OP_RAND_READ, 24'h000104, 8'h8f);
        read_chk(OP_RAND_READ, 24'hfe0280, 8'hc0);
        read_chk(OP_CUR_READ, 24'h0, 8'hc1);
        $display("test reads done");
    endtask

    initial begin
        repeat (12) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        t_idle();
        t_refuse();
        t_writes();
        t_reads();
        stop_test();
    end
endmodule
